// file: sero_pkg.sv
// Constants and types shared by the two-wire EEPROM target logic
`default_nettype none

package sero_pkg;

  // Array geometry
  localparam int          MEM_BYTES   = 256;
  localparam int          ADDR_W      = 8;
  localparam int          PAGE_BYTES  = 8;
  localparam int          PAGE_W      = 3;

  // Fixed upper seven bits of the device address byte (1010000)
  localparam logic [6:0]  DEV_PATTERN = 7'h50;

  // Bit slot positions within one nine-clock byte frame
  localparam logic [3:0]  BIT_LAST    = 4'h7;
  localparam logic [3:0]  ACK_SLOT    = 4'h8;
  localparam logic [3:0]  ACK_END     = 4'h9;

  // Internal programming time and its cycle count at the system clock
  localparam int          CLK_FREQ_KHZ          = 100000;
  localparam int          PROG_TIME_MS          = 5;
  localparam int          INTERNAL_PROG_CYCLES  = PROG_TIME_MS * CLK_FREQ_KHZ;

  // Transfer phases
  typedef enum logic [2:0]
  {
    ST_IDLE  = 3'b000,
    ST_DEV   = 3'b001,
    ST_WADDR = 3'b010,
    ST_WDATA = 3'b011,
    ST_RDATA = 3'b100
  } sero_state_t;

endpackage

`default_nettype wire

// file: sero_target.sv
// Two-wire serial EEPROM target: byte/page write, current, random and sequential read
//
// Behaviour
// - Device address upper seven bits must be 1010000; acknowledge only on match.
// - Last device address bit high selects read, low selects write.
// - Receiver acknowledges each address or data byte by pulling data low in ninth clock.
// - Write sends an 8-bit word address, acknowledged before data is accepted.
// - Stop after an acknowledged write data byte launches self-timed programming.
// - During programming the device ignores all bus traffic.
// - Page write withholds stop and sends up to eight bytes in total.
// - Each page data byte is acknowledged; the closing stop launches programming.
// - Only the low three word address bits increment after each written byte.
// - Passing the page end wraps to the same page start, overwriting earlier bytes.
// - Address polling is acknowledged only once programming has completed.
// - Reads begin like writes but with the read/write bit set to one.
// - Address counter holds last accessed address plus one, wrapping within the page after a write, kept between operations.
// - Read address wraps from the last array byte to the first.
// - Current address read returns the byte at the counter; controller then nacks.
// - Random read: dummy write of address, repeated start, then read.
// - Sequential read continues while the controller acknowledges; nack and stop end it.
`timescale 1ns/1ps
`default_nettype none

module sero_target #(
  parameter int PROG_CYCLES = sero_pkg::INTERNAL_PROG_CYCLES
) (
  // System
  input  wire logic clock,
  input  wire logic resetn,
  // Serial clock from the bus controller
  input  wire logic scl_i,
  // Serial data, open drain
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe
);

  localparam int PW = $clog2(PROG_CYCLES + 1);

  // Pin synchronisers and previous samples for edge detection
  logic                       scl_m_q;
  logic                       scl_s_q;
  logic                       scl_p_q;
  logic                       sda_m_q;
  logic                       sda_s_q;
  logic                       sda_p_q;

  // Protocol state
  sero_pkg::sero_state_t      state_q;
  logic [3:0]                 bit_q;
  logic [7:0]                 shift_q;
  logic [7:0]                 tx_q;
  logic                       rd_go_q;
  logic                       oe_q;

  // Address counter, page buffer, array and programming timer
  logic [sero_pkg::ADDR_W-1:0] addr_q;
  logic [7:0]                 pbuf_q [sero_pkg::PAGE_BYTES];
  logic [sero_pkg::PAGE_BYTES-1:0] pmask_q;
  logic [7:0]                 mem_q  [sero_pkg::MEM_BYTES];
  logic [PW-1:0]              prog_q;

  // Decoded events
  logic                       ev_start;
  logic                       ev_stop;
  logic                       ev_rise;
  logic                       ev_fall;
  logic                       byte_done;
  logic                       ack_end;
  logic                       dev_match;
  logic                       busy;
  logic                       commit;

  // Two flops before any logic looks at the pins
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_p_q <= 1'b1;
    end
    else
    begin
      scl_m_q <= scl_i;
      scl_s_q <= scl_m_q;
      scl_p_q <= scl_s_q;
      sda_m_q <= sda_i;
      sda_s_q <= sda_m_q;
      sda_p_q <= sda_s_q;
    end
  end

  // Bus conditions; data only legally moves while the clock is low
  assign ev_start  = scl_s_q && scl_p_q && sda_p_q && !sda_s_q;
  assign ev_stop   = scl_s_q && scl_p_q && !sda_p_q && sda_s_q;
  assign ev_rise   = scl_s_q && !scl_p_q;
  assign ev_fall   = !scl_s_q && scl_p_q;
  assign byte_done = ev_fall && (bit_q == sero_pkg::ACK_SLOT);
  assign ack_end   = ev_fall && (bit_q == sero_pkg::ACK_END);
  assign dev_match = (shift_q[7:1] == sero_pkg::DEV_PATTERN);
  assign busy      = (prog_q != '0);
  assign commit    = ev_stop && !busy && (pmask_q != '0);

  // Open drain: the pin is only ever pulled low
  assign sda_o  = 1'b0;
  assign sda_oe = oe_q;

  // Phase sequencing and bit slot counting
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      state_q <= sero_pkg::ST_IDLE;
      bit_q   <= 4'h0;
    end
    else if (ev_start)
    begin
      // A start while programming is simply not seen
      state_q <= busy ? sero_pkg::ST_IDLE : sero_pkg::ST_DEV;
      bit_q   <= 4'h0;
    end
    else if (ev_stop)
    begin
      state_q <= sero_pkg::ST_IDLE;
      bit_q   <= 4'h0;
    end
    else if (state_q != sero_pkg::ST_IDLE)
    begin
      if (ev_rise && (bit_q < sero_pkg::ACK_END))
      begin
        bit_q <= bit_q + 4'h1;
      end
      if (byte_done)
      begin
        case (state_q)
          sero_pkg::ST_DEV:
          begin
            if (!dev_match)
            begin
              state_q <= sero_pkg::ST_IDLE;
            end
            else if (shift_q[0])
            begin
              state_q <= sero_pkg::ST_RDATA;
            end
            else
            begin
              state_q <= sero_pkg::ST_WADDR;
            end
          end
          sero_pkg::ST_WADDR: state_q <= sero_pkg::ST_WDATA;
          default:            state_q <= state_q;
        endcase
      end
      if (ack_end)
      begin
        bit_q <= 4'h0;
        // Missing controller acknowledge ends a read; wait for stop
        if ((state_q == sero_pkg::ST_RDATA) && !rd_go_q)
        begin
          state_q <= sero_pkg::ST_IDLE;
        end
      end
    end
  end

  // Shift register, read data and data line drive
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      shift_q <= 8'h00;
      tx_q    <= 8'h00;
      rd_go_q <= 1'b0;
      oe_q    <= 1'b0;
    end
    else if (ev_start || ev_stop || (state_q == sero_pkg::ST_IDLE))
    begin
      oe_q <= 1'b0;
    end
    else
    begin
      if (ev_rise && (bit_q < sero_pkg::ACK_SLOT) && (state_q != sero_pkg::ST_RDATA))
      begin
        shift_q <= {shift_q[6:0], sda_s_q};
      end
      // Ninth rising edge: low means the byte was acknowledged
      if (ev_rise && (bit_q == sero_pkg::ACK_SLOT))
      begin
        rd_go_q <= !sda_s_q;
      end
      if (byte_done)
      begin
        case (state_q)
          sero_pkg::ST_DEV:   oe_q <= dev_match;
          sero_pkg::ST_WADDR: oe_q <= 1'b1;
          sero_pkg::ST_WDATA: oe_q <= 1'b1;
          default:            oe_q <= 1'b0;
        endcase
      end
      else if (ack_end)
      begin
        if ((state_q == sero_pkg::ST_RDATA) && rd_go_q)
        begin
          tx_q <= mem_q[addr_q];
          oe_q <= !mem_q[addr_q][7];
        end
        else
        begin
          oe_q <= 1'b0;
        end
      end
      else if (ev_fall && (state_q == sero_pkg::ST_RDATA) && (bit_q != 4'h0)
               && (bit_q <= sero_pkg::BIT_LAST))
      begin
        tx_q <= {tx_q[6:0], 1'b0};
        oe_q <= !tx_q[6];
      end
    end
  end

  // Address counter and page buffer occupancy
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      addr_q  <= '0;
      pmask_q <= '0;
    end
    else if (ev_start || commit)
    begin
      // A repeated start abandons any unfinished page
      pmask_q <= '0;
    end
    else if (byte_done && (state_q == sero_pkg::ST_WADDR))
    begin
      addr_q  <= shift_q;
      pmask_q <= '0;
    end
    else if (byte_done && (state_q == sero_pkg::ST_WDATA))
    begin
      pmask_q[addr_q[sero_pkg::PAGE_W-1:0]] <= 1'b1;
      addr_q[sero_pkg::PAGE_W-1:0] <= addr_q[sero_pkg::PAGE_W-1:0] + 3'h1;
    end
    else if (ack_end && (state_q == sero_pkg::ST_RDATA) && rd_go_q)
    begin
      addr_q <= addr_q + 8'h01;
    end
  end

  // Page buffer and array; contents are data, left without reset
  always_ff @(posedge clock)
  begin
    if (byte_done && (state_q == sero_pkg::ST_WDATA) && resetn)
    begin
      // Later bytes at the same slot replace earlier ones
      pbuf_q[addr_q[sero_pkg::PAGE_W-1:0]] <= shift_q;
    end
    if (commit && resetn)
    begin
      for (int i = 0; i < sero_pkg::PAGE_BYTES; i++)
      begin
        if (pmask_q[i])
        begin
          mem_q[{addr_q[sero_pkg::ADDR_W-1:sero_pkg::PAGE_W], 3'(i)}] <= pbuf_q[i];
        end
      end
    end
  end

  // Programming timer; array is updated at once, the wait is modelled
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      prog_q <= '0;
    end
    else if (commit)
    begin
      prog_q <= PW'(PROG_CYCLES);
    end
    else if (busy)
    begin
      prog_q <= prog_q - PW'(1);
    end
  end

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  property p_dev_nomatch;
    byte_done && (state_q == sero_pkg::ST_DEV) && !dev_match |=> !sda_oe;
  endproperty
  a_dev_nomatch: assert property (p_dev_nomatch)
    else $error("device acknowledged a foreign address");

  property p_dev_match;
    byte_done && (state_q == sero_pkg::ST_DEV) && dev_match && !ev_start && !ev_stop
      |=> sda_oe && (state_q == ($past(shift_q[0]) ? sero_pkg::ST_RDATA : sero_pkg::ST_WADDR));
  endproperty
  a_dev_match: assert property (p_dev_match)
    else $error("matched address not acknowledged or wrong direction");

  property p_waddr_load;
    byte_done && (state_q == sero_pkg::ST_WADDR) && !ev_start && !ev_stop
      |=> sda_oe && (addr_q == $past(shift_q)) && (state_q == sero_pkg::ST_WDATA);
  endproperty
  a_waddr_load: assert property (p_waddr_load)
    else $error("word address not loaded and acknowledged");

  property p_page_inc;
    byte_done && (state_q == sero_pkg::ST_WDATA) && !ev_start && !ev_stop
      |=> sda_oe && (addr_q[7:3] == $past(addr_q[7:3]))
          && (addr_q[2:0] == 3'($past(addr_q[2:0]) + 3'h1));
  endproperty
  a_page_inc: assert property (p_page_inc)
    else $error("page address did not advance within the page");

  property p_prog_start;
    ev_stop && !busy && (pmask_q != '0) |=> busy ##1 busy;
  endproperty
  a_prog_start: assert property (p_prog_start)
    else $error("stop after write data did not start programming");

  property p_busy_ignore;
    busy && ev_start |=> (state_q == sero_pkg::ST_IDLE) && !sda_oe;
  endproperty
  a_busy_ignore: assert property (p_busy_ignore)
    else $error("start seen while programming");

  property p_prog_count;
    busy |=> (prog_q == PW'($past(prog_q) - PW'(1)));
  endproperty
  a_prog_count: assert property (p_prog_count)
    else $error("programming timer did not count down");

  property p_read_wrap;
    ack_end && (state_q == sero_pkg::ST_RDATA) && rd_go_q && !ev_start && !ev_stop
      |=> (addr_q == 8'($past(addr_q) + 8'h01)) && (sda_oe == !$past(mem_q[addr_q][7]));
  endproperty
  a_read_wrap: assert property (p_read_wrap)
    else $error("read address or first data bit wrong");

  property p_read_nack;
    ack_end && (state_q == sero_pkg::ST_RDATA) && !rd_go_q && !ev_start && !ev_stop
      |=> (state_q == sero_pkg::ST_IDLE) && !sda_oe;
  endproperty
  a_read_nack: assert property (p_read_nack)
    else $error("read continued after controller nack");

  property p_idle_released;
    (state_q == sero_pkg::ST_IDLE) ##1 (state_q == sero_pkg::ST_IDLE) |-> !sda_oe;
  endproperty
  a_idle_released: assert property (p_idle_released)
    else $error("data driven while not addressed");

  c_page_commit: cover property (commit && (pmask_q == 8'hFF));
  c_seq_read:    cover property (ack_end && (state_q == sero_pkg::ST_RDATA) && rd_go_q
                                 ##[1:1000] ack_end && rd_go_q);
  c_poll_busy:   cover property (busy && ev_start);
  c_nomatch:     cover property (byte_done && (state_q == sero_pkg::ST_DEV) && !dev_match);

endmodule

`default_nettype wire

// file: sero_ctl_model.sv
// Behavioural two-wire bus controller that drives the serial clock and data line
`timescale 1ns/1ps
`default_nettype none

module sero_ctl_model #(
  parameter int QTR = 10
) (
  // System
  input  wire logic clock,
  // Serial clock, held high between frames
  output logic      scl_o,
  // Resolved data line and open-drain pull enable
  input  wire logic sda_i,
  output logic      sda_oe
);
  // Bus idle: clock high, data released
  initial
  begin
    scl_o  = 1'b1;
    sda_oe = 1'b0;
  end

  // Quarter bit; at two clocks a quarter the serial clock period is 80 ns
  task automatic qtr();
    repeat (QTR) @(posedge clock);
  endtask

  // Start or repeated start: data falls while the clock is high
  task automatic start();
    sda_oe <= 1'b0;
    qtr();
    scl_o <= 1'b1;
    qtr();
    sda_oe <= 1'b1;
    qtr();
    scl_o <= 1'b0;
    qtr();
  endtask

  // Stop: data rises while the clock is high, bus then left idle
  task automatic stop();
    sda_oe <= 1'b1;
    qtr();
    scl_o <= 1'b1;
    qtr();
    sda_oe <= 1'b0;
    qtr();
  endtask

  // One bit slot: data set while the clock is low, line sampled mid-high
  task automatic xfer(input logic b, output logic s);
    sda_oe <= ~b;
    qtr();
    scl_o <= 1'b1;
    qtr();
    s = sda_i;
    qtr();
    scl_o <= 1'b0;
    qtr();
  endtask

  // Byte out MSB first, then release for the ninth clock
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      xfer(d[i], s);
    xfer(1'b1, s);
    ack = (s === 1'b0);
  endtask

  // Byte in; controller pulls low to go on, releases to end the read
  task automatic rbyte(output logic [7:0] d, input logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      xfer(1'b1, d[i]);
    xfer(~ack, s);
  endtask
endmodule

`default_nettype wire

// file: sero_target_tb_top.sv
// Self-checking bench for the two-wire EEPROM target
`timescale 1ns/1ps
`default_nettype none

module sero_target_tb_top;
  // Shortened programming wait; longer than one polling frame on purpose
  localparam int PROG = 200;

  logic       clock;
  logic       resetn;
  logic       scl;
  logic       dev_oe;
  logic       dev_o;
  logic       ctl_oe;
  logic [7:0] rbuf [8];
  int         err_total;
  int         total_checks;
  // Pull-up on the data line: low while either side pulls
  wire        sda = ~(dev_oe | ctl_oe);

  sero_target #(.PROG_CYCLES(PROG)) uut (.clock(clock), .resetn(resetn), .scl_i(scl),
    .sda_i(sda), .sda_o(dev_o), .sda_oe(dev_oe));
  sero_ctl_model #(.QTR(2)) ctl (.clock(clock), .scl_o(scl), .sda_i(sda), .sda_oe(ctl_oe));

  // Clock
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      err_total++;
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Start, write device address, word address
  task automatic addr_ph(input logic [7:0] a);
    logic k;
    ctl.start();
    ctl.wbyte(8'hA0, k);
    chk("device ack", 8'(k), 8'h01);
    ctl.wbyte(a, k);
    chk("word ack", 8'(k), 8'h01);
  endtask

  // Polls nack while busy, then ack within a bounded number of tries
  task automatic wait_prog();
    logic k;
    int   n;
    ctl.start();
    ctl.wbyte(8'hA0, k);
    ctl.stop();
    chk("busy poll", 8'(k), 8'h00);
    n = 0;
    do
    begin
      ctl.start();
      ctl.wbyte(8'hA0, k);
      ctl.stop();
      n++;
    end while (k !== 1'b1 && n < 8);
    chk("ready poll", 8'(k), 8'h01);
  endtask

  task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
    logic k;
    addr_ph(a);
    ctl.wbyte(d, k);
    chk("data ack", 8'(k), 8'h01);
    ctl.stop();
    wait_prog();
  endtask

  // Optional dummy write, then read n bytes into rbuf
  task automatic read_from(input logic [7:0] a, input int n, input logic rnd);
    logic k;
    if (rnd)
      addr_ph(a);
    ctl.start();
    ctl.wbyte(8'hA1, k);
    chk("read ack", 8'(k), 8'h01);
    for (int i = 0; i < n; i++)
      ctl.rbyte(rbuf[i], i < n - 1);
    ctl.stop();
  endtask

  task automatic t_byte_write();
    wr_byte(8'h10, 8'hA5);
    read_from(8'h10, 1, 1'b1);
    chk("random read", rbuf[0], 8'hA5);
    $display("done: byte write");
  endtask

  // Wrong patterns are never answered, nor are the bytes after them
  task automatic t_bad_addr();
    logic [7:0] bad [4] = '{8'hA2, 8'hB0, 8'h20, 8'hE1};
    logic       k;
    foreach (bad[i])
    begin
      ctl.start();
      ctl.wbyte(bad[i], k);
      chk("mismatch nack", 8'(k), 8'h00);
      ctl.wbyte(8'h00, k);
      chk("ignored byte", 8'(k), 8'h00);
      ctl.stop();
    end
    $display("done: bad address");
  endtask

  // Ten bytes from in-page offset 5 wrap and overwrite the first two
  task automatic t_page_wrap();
    logic k;
    addr_ph(8'h1D);
    for (int i = 0; i < 10; i++)
    begin
      ctl.wbyte(8'hC0 + 8'(i), k);
      chk("page ack", 8'(k), 8'h01);
    end
    ctl.stop();
    wait_prog();
    read_from(8'h00, 1, 1'b0);
    chk("current read", rbuf[0], 8'hC2);
    read_from(8'h18, 8, 1'b1);
    for (int p = 0; p < 8; p++)
      chk("page byte", rbuf[p], 8'hC0 + 8'((p + 3) % 8) + (((p + 3) % 8) < 2 ? 8'h08 : 8'h00));
    $display("done: page wrap");
  endtask

  // Sequential read rolls over from the top byte to the bottom byte
  task automatic t_wrap_read();
    wr_byte(8'hFF, 8'h5A);
    wr_byte(8'h00, 8'h3C);
    read_from(8'hFF, 2, 1'b1);
    chk("top byte", rbuf[0], 8'h5A);
    chk("rolled byte", rbuf[1], 8'h3C);
    // Re-point at the top byte so the current read rolls onto a written byte
    read_from(8'hFF, 1, 1'b1);
    read_from(8'h00, 1, 1'b0);
    chk("counter after", rbuf[0], 8'h3C);
    $display("done: wrap read");
  endtask

  // Watchdog
  initial
  begin
    repeat (90000) @(posedge clock);
    err_total++;
    $display("watchdog expired");
    summarize();
  end

  // Main sequence
  initial
  begin
    err_total    = 0;
    total_checks = 0;
    resetn       = 1'b0;
    repeat (4) @(posedge clock);
    @(negedge clock);
    chk("oe in reset", 8'(dev_oe), 8'h00);
    chk("drive level", 8'(dev_o), 8'h00);
    @(posedge clock);
    resetn <= 1'b1;
    repeat (4) @(posedge clock);
    chk("oe idle", 8'(dev_oe), 8'h00);
    t_byte_write();
    t_bad_addr();
    t_page_wrap();
    t_wrap_read();
    summarize();
  end
endmodule

`default_nettype wire
